// [rtl/pp_map.svh]
// Register offsets, field positions, reset values and timing constants of the port block.
`ifndef PP_MAP_SVH
`define PP_MAP_SVH
`define PP_NPORTS          8
`define PP_NOUT            12
`define PP_NIN             17
`define PP_SEL_LIMIT       16'h0010
`define PP_CLK_PERIOD_NS   32'h0000_000a
`define PP_OFS_CTRL        12'h000
`define PP_OFS_STATUS      12'h004
`define PP_OFS_CMD         12'h008
`define PP_PAGE_GLOBAL     4'h0
`define PP_PAGE_PORT       4'h1
`define PP_PREG_TYPE       3'h0
`define PP_PREG_BASE       3'h1
`define PP_PREG_OUT        3'h2
`define PP_PREG_INV        3'h3
`define PP_PREG_RSTEN      3'h4
`define PP_PREG_RTIME      3'h5
`define PP_PREG_IN         3'h6
`define PP_PREG_INNOT      3'h7
`define PP_CTRL_START      0
`define PP_CTRL_MASK_LSB   8
`define PP_CMD_ALL         4
`define PP_CMD_SEL_LSB     16
`define PP_STAT_RUN        0
`define PP_STAT_ERR        1
`define PP_RST_TYPE        2'h0
`define PP_RST_MASK        8'h00
`define PP_RST_BASE        16'h0000
`define PP_RST_RTIME       32'h0000_0000
`define PP_RESP_OKAY       2'h0
`define PP_RESP_SLVERR     2'h2
`endif

// [rtl/pp_pkg.sv]
// Types shared by the port block modules.
package pp_pkg;
  typedef enum logic [1:0] {PP_TYPE_OUT, PP_TYPE_IN, PP_TYPE_EPP, PP_TYPE_OC} pp_ptype_type;
  typedef enum logic [1:0] {PP_OP_NONE, PP_OP_READ, PP_OP_WRITE, PP_OP_RESET} pp_op_type;
  typedef enum logic [1:0] {PP_ST_CFG, PP_ST_RUN, PP_ST_ERR} pp_state_type;
endpackage : pp_pkg

// [rtl/pp_regbus_if.sv]
// Internal register access strobes between the bus slave and the register file.
`timescale 1ns/1ps
interface pp_regbus_if;
  logic        wr_en;
  logic [11:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  logic        wr_err;
  logic        rd_en;
  logic [11:0] rd_addr;
  logic [31:0] rd_data;
  logic        rd_err;
  modport slave (output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
                 input wr_err, rd_data, rd_err);
  modport regs  (input wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
                 output wr_err, rd_data, rd_err);
endinterface : pp_regbus_if

// [rtl/pp_axil_slave.sv]
// AXI4-Lite slave front end that turns bus transfers into register strobes.
`timescale 1ns/1ps
module pp_axil_slave
  import pp_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // Write channels
  input  wire logic [11:0] awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // Read channels
  input  wire logic [11:0] araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // Register side
  pp_regbus_if.slave       bus
);
  `include "pp_map.svh"
  logic [11:0] awaddr_q, araddr_q;
  logic [31:0] wdata_q, rdata_q;
  logic [3:0]  wstrb_q;
  logic        awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [1:0]  bresp_q, rresp_q;

  // Address and data are taken in either order; the write happens once both are held.
  assign bus.wr_en   = !awready_q && !wready_q && !bvalid_q;
  assign bus.wr_addr = awaddr_q;
  assign bus.wr_data = wdata_q;
  assign bus.wr_strb = wstrb_q;
  assign bus.rd_en   = !arready_q && !rvalid_q;
  assign bus.rd_addr = araddr_q;
  assign {awready, wready, bvalid, bresp} = {awready_q, wready_q, bvalid_q, bresp_q};
  assign {arready, rvalid, rresp, rdata}  = {arready_q, rvalid_q, rresp_q, rdata_q};

  always_ff @(posedge sys_clk or negedge rst_n)
    if (!rst_n)
    begin
      {awready_q, wready_q, bvalid_q} <= 3'b110;
      {awaddr_q, wdata_q, wstrb_q, bresp_q} <= '0;
    end
    else
    begin
      if (awvalid && awready_q)
      begin
        awaddr_q  <= awaddr;
        awready_q <= 1'b0;
      end
      if (wvalid && wready_q)
      begin
        wdata_q  <= wdata;
        wstrb_q  <= wstrb;
        wready_q <= 1'b0;
      end
      if (bus.wr_en)
      begin
        bvalid_q <= 1'b1;
        bresp_q  <= bus.wr_err ? `PP_RESP_SLVERR : `PP_RESP_OKAY;
      end
      else if (bvalid_q && bready)
        {bvalid_q, awready_q, wready_q} <= 3'b011;
    end

  always_ff @(posedge sys_clk or negedge rst_n)
    if (!rst_n)
    begin
      {arready_q, rvalid_q} <= 2'b10;
      {araddr_q, rdata_q, rresp_q} <= '0;
    end
    else if (arvalid && arready_q)
    begin
      araddr_q  <= araddr;
      arready_q <= 1'b0;
    end
    else if (bus.rd_en)
    begin
      rvalid_q <= 1'b1;
      rdata_q  <= bus.rd_data;
      rresp_q  <= bus.rd_err ? `PP_RESP_SLVERR : `PP_RESP_OKAY;
    end
    else if (rvalid_q && rready)
      {rvalid_q, arready_q} <= 2'b01;
endmodule : pp_axil_slave

// [rtl/pp_port_unit.sv]
// One connector: input sampling, output polarity, and the timed return to idle.
`timescale 1ns/1ps
module pp_port_unit
  import pp_pkg::*;
(
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rst_n,
  // Control from the register file
  input  wire logic         run,
  input  pp_ptype_type      ptype,
  input  wire logic         do_read,
  input  wire logic         do_write,
  input  wire logic         do_reset,
  input  wire logic [11:0]  out_val,
  input  wire logic [11:0]  inv,
  input  wire logic [11:0]  rsten,
  input  wire logic [31:0]  rtime,
  // Pins
  input  wire logic [7:0]   data_in,
  input  wire logic [3:0]   ctrl_in,
  input  wire logic [4:0]   stat_in,
  output logic [7:0]        data_out,
  output logic [7:0]        data_oe,
  output logic [3:0]        ctrl_out,
  output logic [3:0]        ctrl_oe,
  output logic              epp_mode,
  // Sampled inputs
  output logic [16:0]       in_true,
  output logic [16:0]       in_not
);
  `include "pp_map.svh"
  logic [16:0] meta_q, sync_q, true_q, not_q;
  logic [11:0] lvl_q;
  logic [31:0] elapsed_q;
  logic        pend_q, fire;
  logic [7:0]  doe_q;
  logic [3:0]  coe_q;
  logic        epp_q;

  assign fire = pend_q && (elapsed_q >= rtime);
  assign {ctrl_out, data_out} = lvl_q;
  assign {data_oe, ctrl_oe, epp_mode, in_true, in_not} = {doe_q, coe_q, epp_q, true_q, not_q};

  always_ff @(posedge sys_clk or negedge rst_n)
    if (!rst_n)
      {meta_q, sync_q} <= '0;
    else
      {sync_q, meta_q} <= {meta_q, stat_in, ctrl_in, data_in};

  always_ff @(posedge sys_clk or negedge rst_n)
    if (!rst_n)
      {true_q, not_q} <= '0;
    else if (do_read)
      {true_q, not_q} <= {sync_q, ~sync_q};

  always_ff @(posedge sys_clk or negedge rst_n)
    if (!rst_n)
      lvl_q <= '0;
    else if (do_write)
      lvl_q <= out_val ^ inv;
    else if (fire)
      lvl_q <= (lvl_q & ~rsten) | (inv & rsten);

  // Elapsed time is kept in nanoseconds and saturates, so no divider is needed.
  always_ff @(posedge sys_clk or negedge rst_n)
    if (!rst_n)
      elapsed_q <= '0;
    else if (do_write)
      elapsed_q <= '0;
    else if (elapsed_q <= ~`PP_CLK_PERIOD_NS)
      elapsed_q <= elapsed_q + `PP_CLK_PERIOD_NS;

  always_ff @(posedge sys_clk or negedge rst_n)
    if (!rst_n)
      pend_q <= 1'b0;
    else if (do_reset)
      pend_q <= 1'b1;
    else if (fire)
      pend_q <= 1'b0;

  always_ff @(posedge sys_clk or negedge rst_n)
    if (!rst_n)
      {doe_q, coe_q, epp_q} <= '0;
    else
    begin
      doe_q <= {8{run && (ptype != PP_TYPE_IN)}};
      coe_q <= {4{run && (ptype != PP_TYPE_OC)}};
      epp_q <= run && (ptype == PP_TYPE_EPP);
    end
endmodule : pp_port_unit

// [rtl/pp_pin_io.sv]
// Top level of the parallel port pin controller: register file, command decode, ports.
//
// The AXI4-Lite register port and the register addresses were decided locally.
`timescale 1ns/1ps
// How it works
// - Seventeen pins: eight data, four control, five status.
// - Output type: data and control driven.
// - Input type: data read, control driven.
// - Open-collector type: data driven, control read.
// - Unset type defaults to output type.
// - Enhanced type: output layout plus electrical mode.
// - Types locked once the block runs.
// - At most eight ports, numbered from zero.
// - Empty port set is an error; no start.
// - Selector below sixteen indexes, else base address.
// - One output per driven pin, two per input.
// - True copy follows pin, inverted copy opposite.
// - Invert flag flips driven output polarity.
// - Per-port 32-bit reset delay in nanoseconds.
// - Reset waits until delay has passed since last write command, drives flagged pins to invert.
// - Read samples one or all ports.
// - Write updates one or all ports.
module pp_pin_io
  import pp_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // AXI4-Lite write channels
  input  wire logic [11:0] awaddr,
  input  wire logic [2:0]  awprot,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // AXI4-Lite read channels
  input  wire logic [11:0] araddr,
  input  wire logic [2:0]  arprot,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // Data pins, eight per port
  input  wire logic [63:0] data_pin_in,
  output logic [63:0]      data_pin_out,
  output logic [63:0]      data_pin_oe,
  // Control pins, four per port
  input  wire logic [31:0] ctrl_pin_in,
  output logic [31:0]      ctrl_pin_out,
  output logic [31:0]      ctrl_pin_oe,
  // Status pins, five per port, always inputs
  input  wire logic [39:0] stat_pin_in,
  // Electrical mode request per port
  output logic [7:0]       epp_mode
);
  `include "pp_map.svh"

  // ----------------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------------
  pp_regbus_if bus ();
  pp_state_type state_q;
  pp_ptype_type type_q   [`PP_NPORTS];
  logic [15:0]  base_q   [`PP_NPORTS];
  logic [11:0]  out_q    [`PP_NPORTS];
  logic [11:0]  inv_q    [`PP_NPORTS];
  logic [11:0]  rsten_q  [`PP_NPORTS];
  logic [31:0]  rtime_q  [`PP_NPORTS];
  logic [16:0]  in_true  [`PP_NPORTS];
  logic [16:0]  in_not   [`PP_NPORTS];
  logic [7:0]   mask_q;
  logic [7:0]   rd_cmd_q;
  logic [7:0]   wr_cmd_q;
  logic [7:0]   rs_cmd_q;
  logic [7:0]   hit;
  logic [31:0]  wr_word;
  logic [31:0]  rd_word;
  logic [31:0]  old_word;
  logic [31:0]  status_word;
  logic         wr_known;
  logic         rd_known;
  logic         wr_global;
  logic         wr_port;
  logic         locked;
  logic [2:0]   wr_pidx;
  logic [2:0]   wr_ridx;
  logic [2:0]   rd_pidx;
  logic [2:0]   rd_ridx;
  logic [15:0]  cmd_sel;
  logic         sel_is_index;
  pp_op_type    cmd_op;
  logic         cmd_all;
  logic         cmd_go;
  logic [7:0]   new_mask;
  logic         start_req;

  // ----------------------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------------------
  pp_axil_slave u_slave (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .awaddr  (awaddr),
    .awvalid (awvalid),
    .awready (awready),
    .wdata   (wdata),
    .wstrb   (wstrb),
    .wvalid  (wvalid),
    .wready  (wready),
    .bresp   (bresp),
    .bvalid  (bvalid),
    .bready  (bready),
    .araddr  (araddr),
    .arvalid (arvalid),
    .arready (arready),
    .rdata   (rdata),
    .rresp   (rresp),
    .rvalid  (rvalid),
    .rready  (rready),
    .bus     (bus)
  );

  // ----------------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------------
  // Protection bits carry no meaning here; every access is treated alike.
  assign wr_pidx   = bus.wr_addr[7:5];
  assign wr_ridx   = bus.wr_addr[4:2];
  assign rd_pidx   = bus.rd_addr[7:5];
  assign rd_ridx   = bus.rd_addr[4:2];
  assign wr_global = bus.wr_addr[11:8] == `PP_PAGE_GLOBAL;
  // Unaligned port addresses fall outside the map and answer with an error.
  assign wr_port   = (bus.wr_addr[11:8] == `PP_PAGE_PORT) && (bus.wr_addr[1:0] == 2'h0);
  assign wr_known  = wr_port || (wr_global && ((bus.wr_addr == `PP_OFS_CTRL) ||
                     (bus.wr_addr == `PP_OFS_STATUS) || (bus.wr_addr == `PP_OFS_CMD)));
  assign rd_known  = ((bus.rd_addr[11:8] == `PP_PAGE_PORT) && (bus.rd_addr[1:0] == 2'h0)) ||
                     (bus.rd_addr == `PP_OFS_CTRL) || (bus.rd_addr == `PP_OFS_STATUS) ||
                     (bus.rd_addr == `PP_OFS_CMD);
  assign bus.wr_err = !wr_known;
  assign bus.rd_err = !rd_known;
  assign locked    = state_q == PP_ST_RUN;

  // Byte lanes not strobed keep the register's previous content.
  always_comb
  begin
    old_word = 32'h0000_0000;
    // Of the global words only the control word has content to merge; commands must not pick up the mask.
    if (bus.wr_addr == `PP_OFS_CTRL)
      old_word = {16'h0000, mask_q, 8'h00};
    else if (wr_port)
      case (wr_ridx)
        `PP_PREG_TYPE:  old_word = {30'h0000_0000, type_q[wr_pidx]};
        `PP_PREG_BASE:  old_word = {16'h0000, base_q[wr_pidx]};
        `PP_PREG_OUT:   old_word = {20'h00000, out_q[wr_pidx]};
        `PP_PREG_INV:   old_word = {20'h00000, inv_q[wr_pidx]};
        `PP_PREG_RSTEN: old_word = {20'h00000, rsten_q[wr_pidx]};
        `PP_PREG_RTIME: old_word = rtime_q[wr_pidx];
        default:        old_word = 32'h0000_0000;
      endcase
  end

  always_comb
  begin
    wr_word = old_word;
    for (int b = 0; b < 4; b++)
      if (bus.wr_strb[b])
        wr_word[b*8 +: 8] = bus.wr_data[b*8 +: 8];
  end

  // ----------------------------------------------------------------------------
  // Start-up and configuration state
  // ----------------------------------------------------------------------------
  assign start_req = bus.wr_en && (bus.wr_addr == `PP_OFS_CTRL) && wr_word[`PP_CTRL_START];
  assign new_mask  = wr_word[`PP_CTRL_MASK_LSB +: 8];

  always_ff @(posedge sys_clk or negedge rst_n)
    if (!rst_n)
      mask_q <= `PP_RST_MASK;
    else if (bus.wr_en && !locked && (bus.wr_addr == `PP_OFS_CTRL))
      mask_q <= new_mask;

  // Once running, types and mask stay put; only a reset returns to configuration.
  always_ff @(posedge sys_clk or negedge rst_n)
    if (!rst_n)
      state_q <= PP_ST_CFG;
    else
      case (state_q)
        PP_ST_CFG, PP_ST_ERR:
          if (start_req)
            state_q <= (new_mask == 8'h00) ? PP_ST_ERR : PP_ST_RUN;
        PP_ST_RUN:
          state_q <= PP_ST_RUN;
        default:
          state_q <= PP_ST_CFG;
      endcase

  // ----------------------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------------------
  // Commands written before start are dropped, since no port layout is settled yet.
  assign cmd_go  = bus.wr_en && locked && (bus.wr_addr == `PP_OFS_CMD);
  assign cmd_op  = pp_op_type'(wr_word[1:0]);
  assign cmd_all = wr_word[`PP_CMD_ALL];
  assign cmd_sel = wr_word[`PP_CMD_SEL_LSB +: 16];
  assign sel_is_index = cmd_sel < `PP_SEL_LIMIT;

  // ----------------------------------------------------------------------------
  // Per-port registers and pin logic
  // ----------------------------------------------------------------------------
  generate
    for (genvar p = 0; p < `PP_NPORTS; p++)
    begin : g_port
      logic wr_this;
      logic idx_match;
      logic base_match;

      assign wr_this = bus.wr_en && wr_port && (wr_pidx == 3'(p));
      // A base address below sixteen can never match, as such values always index.
      assign idx_match  = sel_is_index && (cmd_sel[3:0] == 4'(p));
      assign base_match = !sel_is_index && (cmd_sel == base_q[p]);
      assign hit[p]     = mask_q[p] && (cmd_all || idx_match || base_match);

      always_ff @(posedge sys_clk or negedge rst_n)
        if (!rst_n)
        begin
          type_q[p] <= pp_ptype_type'(`PP_RST_TYPE);
          base_q[p] <= `PP_RST_BASE;
        end
        else if (wr_this && !locked)
        begin
          if (wr_ridx == `PP_PREG_TYPE)
            type_q[p] <= pp_ptype_type'(wr_word[1:0]);
          if (wr_ridx == `PP_PREG_BASE)
            base_q[p] <= wr_word[15:0];
        end

      always_ff @(posedge sys_clk or negedge rst_n)
        if (!rst_n)
        begin
          out_q[p]   <= '0;
          inv_q[p]   <= '0;
          rsten_q[p] <= '0;
          rtime_q[p] <= `PP_RST_RTIME;
        end
        else if (wr_this)
        begin
          if (wr_ridx == `PP_PREG_OUT)
            out_q[p] <= wr_word[11:0];
          if (wr_ridx == `PP_PREG_INV)
            inv_q[p] <= wr_word[11:0];
          if (wr_ridx == `PP_PREG_RSTEN)
            rsten_q[p] <= wr_word[11:0];
          if (wr_ridx == `PP_PREG_RTIME)
            rtime_q[p] <= wr_word;
        end

      // Commands become one-cycle strobes so every port acts in the same clock.
      always_ff @(posedge sys_clk or negedge rst_n)
        if (!rst_n)
        begin
          rd_cmd_q[p] <= 1'b0;
          wr_cmd_q[p] <= 1'b0;
          rs_cmd_q[p] <= 1'b0;
        end
        else
        begin
          rd_cmd_q[p] <= cmd_go && hit[p] && (cmd_op == PP_OP_READ);
          wr_cmd_q[p] <= cmd_go && hit[p] && (cmd_op == PP_OP_WRITE);
          rs_cmd_q[p] <= cmd_go && hit[p] && (cmd_op == PP_OP_RESET);
        end

      pp_port_unit u_port (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .run      (locked && mask_q[p]),
        .ptype    (type_q[p]),
        .do_read  (rd_cmd_q[p]),
        .do_write (wr_cmd_q[p]),
        .do_reset (rs_cmd_q[p]),
        .out_val  (out_q[p]),
        .inv      (inv_q[p]),
        .rsten    (rsten_q[p]),
        .rtime    (rtime_q[p]),
        .data_in  (data_pin_in[p*8 +: 8]),
        .ctrl_in  (ctrl_pin_in[p*4 +: 4]),
        .stat_in  (stat_pin_in[p*5 +: 5]),
        .data_out (data_pin_out[p*8 +: 8]),
        .data_oe  (data_pin_oe[p*8 +: 8]),
        .ctrl_out (ctrl_pin_out[p*4 +: 4]),
        .ctrl_oe  (ctrl_pin_oe[p*4 +: 4]),
        .epp_mode (epp_mode[p]),
        .in_true  (in_true[p]),
        .in_not   (in_not[p])
      );
    end
  endgenerate

  // ----------------------------------------------------------------------------
  // Status word
  // ----------------------------------------------------------------------------
  // An error start leaves the block in the error state, from which software may retry.
  always_comb
  begin
    status_word = 32'h0000_0000;
    status_word[`PP_STAT_RUN] = state_q == PP_ST_RUN;
    status_word[`PP_STAT_ERR] = state_q == PP_ST_ERR;
  end

  // ----------------------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------------------
  always_comb
  begin
    rd_word = 32'h0000_0000;
    if (bus.rd_addr[11:8] == `PP_PAGE_PORT)
      case (rd_ridx)
        `PP_PREG_TYPE:  rd_word = {30'h0000_0000, type_q[rd_pidx]};
        `PP_PREG_BASE:  rd_word = {16'h0000, base_q[rd_pidx]};
        `PP_PREG_OUT:   rd_word = {20'h00000, out_q[rd_pidx]};
        `PP_PREG_INV:   rd_word = {20'h00000, inv_q[rd_pidx]};
        `PP_PREG_RSTEN: rd_word = {20'h00000, rsten_q[rd_pidx]};
        `PP_PREG_RTIME: rd_word = rtime_q[rd_pidx];
        `PP_PREG_IN:    rd_word = {15'h0000, in_true[rd_pidx]};
        `PP_PREG_INNOT: rd_word = {15'h0000, in_not[rd_pidx]};
        default:        rd_word = 32'h0000_0000;
      endcase
    else if (bus.rd_addr == `PP_OFS_CTRL)
      rd_word = {16'h0000, mask_q, 8'h00};
    else if (bus.rd_addr == `PP_OFS_STATUS)
      rd_word = status_word;
  end

  // Command register reads as zero because commands act once and leave nothing behind.
  assign bus.rd_data = rd_word;
endmodule : pp_pin_io

// [test/pp_pin_io_props.sv]
// Checker of the bus answers and pin enables of the port block.
`timescale 1ns/1ps
module pp_pin_io_props (
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        rst_n,
  // Bus handshakes
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic        bvalid,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic        rvalid,
  // Pin enables
  input wire logic [63:0] data_pin_oe,
  input wire logic [31:0] ctrl_pin_oe,
  input wire logic [7:0]  epp_mode
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  property p_wr_ans;
    awvalid && awready && wvalid && wready |-> ##1 !awready ##1 bvalid;
  endproperty
  a_wr_ans: assert property (p_wr_ans) else $error("write answer off");
  property p_rd_ans;
    arvalid && arready |-> ##1 !arready ##1 rvalid;
  endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read answer off");
  property p_aw_w;
    $fell(bvalid) |-> awready && wready;
  endproperty
  a_aw_w: assert property (p_aw_w) else $error("ready not restored");
  property p_b_busy;
    bvalid |-> !awready;
  endproperty
  a_b_busy: assert property (p_b_busy) else $error("write taken early");
  property p_r_busy;
    rvalid |-> !arready;
  endproperty
  a_r_busy: assert property (p_r_busy) else $error("read taken early");
  property p_data_grp;
    data_pin_oe[7:0] == 8'h00 || data_pin_oe[7:0] == 8'hff;
  endproperty
  a_data_grp: assert property (p_data_grp) else $error("data group split");
  property p_ctrl_grp;
    ctrl_pin_oe[3:0] == 4'h0 || ctrl_pin_oe[3:0] == 4'hf;
  endproperty
  a_ctrl_grp: assert property (p_ctrl_grp) else $error("ctrl group split");
  property p_epp;
    epp_mode[2] |-> data_pin_oe[23:16] == 8'hff && ctrl_pin_oe[11:8] == 4'hf;
  endproperty
  a_epp: assert property (p_epp) else $error("enhanced layout");
  property p_lock;
    |data_pin_oe[7:0] |=> $stable(data_pin_oe[7:0]) && $stable(ctrl_pin_oe[3:0]);
  endproperty
  a_lock: assert property (p_lock) else $error("direction changed");
endmodule : pp_pin_io_props

bind pp_pin_io pp_pin_io_props u_props (.*);

// [test/pp_ext_hw.sv]
// Connector hardware: attached levels meet the block's drivers on each pin.
`timescale 1ns/1ps
module pp_ext_hw (
  // Block drivers
  input  wire logic [63:0] data_pin_out,
  input  wire logic [63:0] data_pin_oe,
  input  wire logic [31:0] ctrl_pin_out,
  input  wire logic [31:0] ctrl_pin_oe,
  // Levels the attached hardware applies
  input  wire logic [63:0] ext_data,
  input  wire logic [31:0] ext_ctrl,
  // Wire levels fed back
  output logic [63:0]      data_lvl,
  output logic [31:0]      ctrl_lvl
);
  // Contention is not modelled, so a driven pin simply shows the block's level.
  assign data_lvl = (data_pin_out & data_pin_oe) | (ext_data & ~data_pin_oe);
  assign ctrl_lvl = (ctrl_pin_out & ctrl_pin_oe) | (ext_ctrl & ~ctrl_pin_oe);
endmodule : pp_ext_hw

// [test/pp_pin_io_tb.sv]
// Self-checking bench of the parallel port pin block.
`timescale 1ns/1ps
module pp_pin_io_tb;
  logic        sys_clk = 1'b0, rst_n = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000, v, iv;
  logic [31:0] wdata = 32'h0, rdata, ext_c = 32'h0, clv, cpo, coe;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, bq[$];
  logic [63:0] ext_d = 64'h0, dlv, dpo, doe;
  logic [39:0] stat = 40'h0;
  logic [7:0]  epp;
  logic [16:0] pins;
  logic [33:0] rq[$];
  logic [12:0] oe_exp[8] = '{13'h0fff, 13'h0f00, 13'h1fff, 13'h00ff, 13'h0fff, 13'h0fff,
                             13'h0000, 13'h0000};
  int          error_cnt = 0, check_count = 0, cyc = 0;
  always #5 sys_clk = ~sys_clk;
  pp_pin_io uut (.sys_clk, .rst_n, .awaddr, .awprot(3'h0), .awvalid, .awready, .wdata,
    .wstrb(4'hf), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arprot(3'h0),
    .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .data_pin_in(dlv),
    .data_pin_out(dpo), .data_pin_oe(doe), .ctrl_pin_in(clv), .ctrl_pin_out(cpo),
    .ctrl_pin_oe(coe), .stat_pin_in(stat), .epp_mode(epp));
  pp_ext_hw u_ext (.data_pin_out(dpo), .data_pin_oe(doe), .ctrl_pin_out(cpo),
    .ctrl_pin_oe(coe), .ext_data(ext_d), .ext_ctrl(ext_c), .data_lvl(dlv), .ctrl_lvl(clv));
  // --------
  // Helpers
  // --------
  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic final_report;
    if (error_cnt == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : final_report
  function automatic logic [11:0] pa(input int p, input logic [11:0] o);
    return 12'h100 + 12'(p) * 12'h020 + o;
  endfunction : pa
  function automatic logic [11:0] pin(input int p);
    return {cpo[4*p+:4], dpo[8*p+:8]};
  endfunction : pin
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
    @(posedge sys_clk);
    bq.push_back(r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    while (awvalid && !awready || wvalid && !wready);
    while (!bvalid) @(posedge sys_clk);
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [33:0] e);
    @(posedge sys_clk);
    rq.push_back(e);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge sys_clk); while (!arready);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge sys_clk);
    rready <= 1'b0;
  endtask : rd
  // Pins follow OUT xor INV two edges after the command write completes.
  task automatic put(input int p, input logic [31:0] cmd);
    v = 12'($urandom);
    iv = 12'($urandom);
    wr(pa(p, 12'h008), 32'(v));
    wr(pa(p, 12'h00c), 32'(iv));
    wr(12'h008, cmd);
    repeat (2) @(posedge sys_clk);
    chk(34'(pin(p)), 34'(v ^ iv));
  endtask : put
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (bvalid && bready) chk(34'(bresp), 34'(bq.pop_front()));
    if (rvalid && rready) chk({rresp, rdata}, rq.pop_front());
    if (cyc == 5000)
    begin
      error_cnt++;
      final_report();
    end
  end
  initial
  begin
    void'($urandom(32'h6d07));
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(12'h004, 34'h0);
    rd(pa(4, 12'h000), 34'h0);
    wr(12'h000, 32'h1);
    rd(12'h004, 34'h2);
    chk(34'(|{doe, coe}), 34'h0);
    for (int p = 0; p < 4; p++) wr(pa(p, 12'h000), 32'(p));
    wr(pa(5, 12'h004), 32'h378);
    wr(12'h000, 32'h3f01);
    repeat (3) @(posedge sys_clk);
    for (int p = 0; p < 8; p++) chk({epp[p], coe[4*p+:4], doe[8*p+:8]}, 34'(oe_exp[p]));
    wr(pa(0, 12'h000), 32'h1);
    rd(pa(0, 12'h000), 34'h0);
    put(0, 32'h0000_0002);
    put(5, 32'h0378_0002);
    put(4, 32'h0000_0012);
    for (int p = 1; p < 4; p += 2)
    begin
      ext_d <= {$urandom, $urandom};
      ext_c <= $urandom;
      stat <= 40'({$urandom, $urandom});
      repeat (3) @(posedge sys_clk);
      wr(12'h008, p == 1 ? 32'h0001_0001 : 32'h0000_0011);
      pins = {stat[5*p+:5], clv[4*p+:4], dlv[8*p+:8]};
      rd(pa(p, 12'h018), {17'h0, pins});
      rd(pa(p, 12'h01c), {17'h0, ~pins});
    end
    wr(pa(0, 12'h010), 32'h0f5);
    wr(pa(0, 12'h014), 32'h64);
    put(0, 32'h0000_0002);
    wr(12'h008, 32'h0000_0003);
    repeat (4) @(posedge sys_clk);
    chk(34'(pin(0)), 34'(v ^ iv));
    repeat (10) @(posedge sys_clk);
    chk(34'(pin(0)), 34'((v ^ iv) & ~12'h0f5 | iv & 12'h0f5));
    rd(pa(8, 12'h000), {2'h2, 32'h0});
    wr(pa(8, 12'h000), 32'h1, 2'h2);
    final_report();
  end
endmodule : pp_pin_io_tb
